// *** verilog/cfe_core.sv ***
// Condition flag evaluator: answers sequencer tests from core flags.
// Assumes all inputs synchronous to aclk; AXI4-Lite register slave.
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps

module cfe_core #(
    parameter int BIO_W = 4,
    parameter int BMU_W = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Sequencer test port
    input wire logic test_valid,
    input wire logic [4:0] test_code,
    output logic cond_true,
    // Arithmetic flag update
    input wire logic dau_update,
    input wire logic dau_negative,
    input wire logic dau_zero,
    input wire logic dau_logical_ovf,
    input wire logic dau_math_ovf,
    // Bit-I/O comparison
    input wire logic [BIO_W-1:0] bit_io_tested,
    input wire logic [BIO_W-1:0] bit_io_matched,
    output logic [15:0] bit_io_ctrl,
    // Bit-manipulation result
    input wire logic bmu_update,
    input wire logic [BMU_W-1:0] bmu_result,
    // Miscellaneous condition sources
    input wire logic debug_prog_irq,
    input wire logic testport_irq,
    input wire logic pll_locked,
    input wire logic coproc_busy,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int CW = cfe_pkg::CNT_W;
    localparam int LW = cfe_pkg::LFSR_W;

    // Flag and state registers
    logic result_negative_flag_reg;
    logic result_zero_flag_reg;
    logic logical_overflow_flag_reg;
    logic math_overflow_flag_reg;
    logic [CW-1:0] count_a_reg;
    logic [CW-1:0] count_a_next;
    logic [CW-1:0] count_b_reg;
    logic [CW-1:0] count_b_next;
    logic [LW-1:0] lfsr_reg;
    logic [LW-1:0] lfsr_next;
    logic [15:0] bio_ctrl_reg;
    logic bio_armed_reg;
    logic [BMU_W-1:0] bmu_result_reg;

    // Bus registers
    logic aw_hold_reg;
    logic [7:0] awaddr_reg;
    logic w_hold_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // Write decode
    wire do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire wr_count_a = do_write && awaddr_reg == cfe_pkg::OFF_COUNT_A;
    wire wr_count_b = do_write && awaddr_reg == cfe_pkg::OFF_COUNT_B;
    wire wr_bio = do_write && awaddr_reg == cfe_pkg::OFF_BIO_CTRL;
    wire wr_seed = do_write && awaddr_reg == cfe_pkg::OFF_SEED;
    wire wr_status = do_write && awaddr_reg == cfe_pkg::OFF_STATUS;
    wire wr_mapped = wr_count_a || wr_count_b || wr_bio || wr_seed || wr_status;
    wire [15:0] wr_low = {wstrb_reg[1] ? wdata_reg[15:8] : 8'h00,
                          wstrb_reg[0] ? wdata_reg[7:0] : 8'h00};
    wire [15:0] wr_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

    // Evaluation strobes
    wire [4:0] code = test_code;
    wire fire = test_valid;
    wire fire_a = fire && (code == cfe_pkg::TC_CA_GE || code == cfe_pkg::TC_CA_LT);
    wire fire_b = fire && (code == cfe_pkg::TC_CB_GE || code == cfe_pkg::TC_CB_LT);
    wire fire_rnd = fire && (code == cfe_pkg::TC_HEADS || code == cfe_pkg::TC_TAILS);

    // Derived conditions
    wire rand_bit = lfsr_reg[0];
    wire lfsr_fb = lfsr_reg[LW-1] ^ lfsr_reg[cfe_pkg::LFSR_TAP];
    wire [BIO_W-1:0] bio_hit = bit_io_tested & bit_io_matched;
    wire [BIO_W-1:0] bio_miss = bit_io_tested & ~bit_io_matched;
    wire bmu_parity = ^bmu_result_reg;
    wire bmu_minus_one = &bmu_result_reg;
    wire n_f = result_negative_flag_reg;
    wire z_f = result_zero_flag_reg;

    // Result table indexed by test code
    logic [31:0] cond_vec;
    assign cond_vec[cfe_pkg::TC_NONNEG] = !n_f;
    assign cond_vec[cfe_pkg::TC_NEG] = n_f;
    assign cond_vec[cfe_pkg::TC_ZERO] = z_f;
    assign cond_vec[cfe_pkg::TC_NONZERO] = !z_f;
    assign cond_vec[cfe_pkg::TC_POS] = !n_f && !z_f;
    assign cond_vec[cfe_pkg::TC_NOTPOS] = n_f || z_f;
    assign cond_vec[cfe_pkg::TC_LV_SET] = logical_overflow_flag_reg;
    assign cond_vec[cfe_pkg::TC_LV_CLR] = !logical_overflow_flag_reg;
    assign cond_vec[cfe_pkg::TC_MV_SET] = math_overflow_flag_reg;
    assign cond_vec[cfe_pkg::TC_MV_CLR] = !math_overflow_flag_reg;
    assign cond_vec[cfe_pkg::TC_CA_GE] = !count_a_reg[CW-1];
    assign cond_vec[cfe_pkg::TC_CA_LT] = count_a_reg[CW-1];
    assign cond_vec[cfe_pkg::TC_CB_GE] = !count_b_reg[CW-1];
    assign cond_vec[cfe_pkg::TC_CB_LT] = count_b_reg[CW-1];
    assign cond_vec[cfe_pkg::TC_HEADS] = rand_bit;
    assign cond_vec[cfe_pkg::TC_TAILS] = !rand_bit;
    assign cond_vec[cfe_pkg::TC_TRUE] = 1'b1;
    assign cond_vec[cfe_pkg::TC_FALSE] = 1'b0;
    assign cond_vec[cfe_pkg::TC_ALL_T] = bio_armed_reg && !(|bio_miss);
    assign cond_vec[cfe_pkg::TC_ALL_F] = bio_armed_reg && !(|bio_hit);
    assign cond_vec[cfe_pkg::TC_SOME_T] = bio_armed_reg && (|bio_hit);
    assign cond_vec[cfe_pkg::TC_SOME_F] = bio_armed_reg && (|bio_miss);
    assign cond_vec[cfe_pkg::TC_ODDP] = bmu_parity;
    assign cond_vec[cfe_pkg::TC_EVENP] = !bmu_parity;
    assign cond_vec[cfe_pkg::TC_MINUS1] = bmu_minus_one;
    assign cond_vec[cfe_pkg::TC_NOT_MINUS1] = !bmu_minus_one;
    assign cond_vec[cfe_pkg::TC_NO_DBG] = !debug_prog_irq;
    assign cond_vec[cfe_pkg::TC_NO_TP] = !testport_irq;
    assign cond_vec[cfe_pkg::TC_LOCK] = pll_locked;
    assign cond_vec[cfe_pkg::TC_BUSY] = coproc_busy;
    // Unused codes answer false
    assign cond_vec[31:30] = 2'h0;

    assign cond_true = test_valid && cond_vec[code];

    assign count_a_next = wr_count_a ? ((count_a_reg & ~wr_mask) | wr_low)
                        : fire_a ? count_a_reg + 16'h0001 : count_a_reg;
    assign count_b_next = wr_count_b ? ((count_b_reg & ~wr_mask) | wr_low)
                        : fire_b ? count_b_reg + 16'h0001 : count_b_reg;

    assign lfsr_next = (wr_seed && wdata_reg[LW-1:0] != 10'h000) ? wdata_reg[LW-1:0]
                     : fire_rnd ? {lfsr_reg[LW-2:0], lfsr_fb} : lfsr_reg;

    // Status word
    logic [15:0] status_word;
    assign status_word[cfe_pkg::ST_NEG] = n_f;
    assign status_word[cfe_pkg::ST_ZERO] = z_f;
    assign status_word[cfe_pkg::ST_LV] = logical_overflow_flag_reg;
    assign status_word[cfe_pkg::ST_MV] = math_overflow_flag_reg;
    assign status_word[cfe_pkg::ST_RAND] = rand_bit;
    assign status_word[cfe_pkg::ST_BIO_ARM] = bio_armed_reg;
    assign status_word[cfe_pkg::ST_LOCK] = pll_locked;
    assign status_word[cfe_pkg::ST_BUSY] = coproc_busy;
    assign status_word[cfe_pkg::ST_PARITY] = bmu_parity;
    assign status_word[cfe_pkg::ST_MINUS1] = bmu_minus_one;
    assign status_word[15:10] = 6'h00;

    // Read decode
    wire [7:0] ra = s_axi_araddr;
    wire rd_hit = ra == cfe_pkg::OFF_COUNT_A || ra == cfe_pkg::OFF_COUNT_B
               || ra == cfe_pkg::OFF_BIO_CTRL || ra == cfe_pkg::OFF_STATUS
               || ra == cfe_pkg::OFF_SEED;
    wire [15:0] rd_word = ra == cfe_pkg::OFF_COUNT_A ? count_a_reg
                        : ra == cfe_pkg::OFF_COUNT_B ? count_b_reg
                        : ra == cfe_pkg::OFF_BIO_CTRL ? bio_ctrl_reg
                        : ra == cfe_pkg::OFF_STATUS ? status_word
                        : ra == cfe_pkg::OFF_SEED ? {6'h00, lfsr_reg} : 16'h0000;

    // Bus handshakes
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign bit_io_ctrl = bio_ctrl_reg;

    // Write address and data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            w_hold_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (do_write) begin
                aw_hold_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (do_write) begin
                w_hold_reg <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= cfe_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? cfe_pkg::RESP_OKAY : cfe_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= cfe_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {16'h0000, rd_word};
            rresp_reg <= rd_hit ? cfe_pkg::RESP_OKAY : cfe_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_negative_flag_reg <= 1'b0;
            result_zero_flag_reg <= 1'b0;
            logical_overflow_flag_reg <= 1'b0;
            math_overflow_flag_reg <= 1'b0;
        end else if (dau_update) begin
            result_negative_flag_reg <= dau_negative;
            result_zero_flag_reg <= dau_zero;
            logical_overflow_flag_reg <= dau_logical_ovf;
            math_overflow_flag_reg <= dau_math_ovf;
        end
    end

    // Counters and generator step once per test that reads them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_a_reg <= cfe_pkg::COUNT_RST;
            count_b_reg <= cfe_pkg::COUNT_RST;
            lfsr_reg <= cfe_pkg::LFSR_RST;
        end else begin
            count_a_reg <= count_a_next;
            count_b_reg <= count_b_next;
            lfsr_reg <= lfsr_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bio_ctrl_reg <= cfe_pkg::BIO_CTRL_RST;
            bio_armed_reg <= 1'b0;
        end else if (wr_bio) begin
            bio_ctrl_reg <= (bio_ctrl_reg & ~wr_mask) | wr_low;
            bio_armed_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bmu_result_reg <= '0;
        end else if (bmu_update) begin
            bmu_result_reg <= bmu_result;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sign_test_a: assert property (
        test_valid && code == cfe_pkg::TC_NONNEG |-> cond_true == !n_f)
        else $error("nonnegative test wrong");
    zero_test_a: assert property (
        test_valid && code == cfe_pkg::TC_NONZERO |-> cond_true != z_f)
        else $error("nonzero test wrong");
    pos_test_a: assert property (
        test_valid && code == cfe_pkg::TC_POS && cond_true |-> !n_f && !z_f)
        else $error("positive test wrong");
    lovf_test_a: assert property (
        test_valid && code == cfe_pkg::TC_LV_CLR |-> cond_true == !logical_overflow_flag_reg)
        else $error("logical overflow test wrong");
    count_sign_a: assert property (
        test_valid && code == cfe_pkg::TC_CB_LT |-> cond_true == count_b_reg[CW-1])
        else $error("counter sign test wrong");
    count_inc_a: assert property (
        fire_a && !wr_count_a |=> count_a_reg == $past(count_a_reg) + 16'h0001)
        else $error("counter not incremented");
    lfsr_step_a: assert property (
        fire_rnd && !wr_seed |=> lfsr_reg == {$past(lfsr_reg[LW-2:0]), $past(lfsr_fb)})
        else $error("generator did not step");
    lfsr_hold_a: assert property (
        !fire_rnd && !wr_seed |=> $stable(lfsr_reg))
        else $error("generator moved without a test");
    bio_gate_a: assert property (
        !bio_armed_reg && code inside {[cfe_pkg::TC_ALL_T:cfe_pkg::TC_SOME_F]}
        |-> !cond_true)
        else $error("bit-io test true before arming");
    always_false_a: assert property (
        code == cfe_pkg::TC_FALSE |-> !cond_true)
        else $error("false code answered true");
    flag_hold_a: assert property (
        !dau_update [*2] |=> $stable(result_negative_flag_reg) && $stable(z_f))
        else $error("flags changed without update");

    count_cov: cover property (fire_a ##1 fire_a);
    heads_cov: cover property (fire_rnd && cond_true);
    bio_cov: cover property (wr_bio ##[1:10] test_valid && code == cfe_pkg::TC_SOME_T);
    write_cov: cover property (do_write ##1 s_axi_bvalid && s_axi_bready);
endmodule // cfe_core

// *** verilog/cfe_pkg.sv ***
// Constants for the condition flag evaluator.
// Assumes one core clock; register map reached over AXI4-Lite.
package cfe_pkg;
    // Test codes from the instruction sequencer
    typedef enum logic [4:0] {
        TC_NONNEG = 5'h00, TC_NEG = 5'h01, TC_ZERO = 5'h02, TC_NONZERO = 5'h03,
        TC_POS = 5'h04, TC_NOTPOS = 5'h05, TC_LV_SET = 5'h06, TC_LV_CLR = 5'h07,
        TC_MV_SET = 5'h08, TC_MV_CLR = 5'h09, TC_CA_GE = 5'h0a, TC_CA_LT = 5'h0b,
        TC_CB_GE = 5'h0c, TC_CB_LT = 5'h0d, TC_HEADS = 5'h0e, TC_TAILS = 5'h0f,
        TC_TRUE = 5'h10, TC_FALSE = 5'h11, TC_ALL_T = 5'h12, TC_ALL_F = 5'h13,
        TC_SOME_T = 5'h14, TC_SOME_F = 5'h15, TC_ODDP = 5'h16, TC_EVENP = 5'h17,
        TC_MINUS1 = 5'h18, TC_NOT_MINUS1 = 5'h19, TC_NO_DBG = 5'h1a, TC_NO_TP = 5'h1b,
        TC_LOCK = 5'h1c, TC_BUSY = 5'h1d
    } cfe_test_t;
    // Register byte offsets
    localparam logic [7:0] OFF_COUNT_A = 8'h00;
    localparam logic [7:0] OFF_COUNT_B = 8'h04;
    localparam logic [7:0] OFF_BIO_CTRL = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_SEED = 8'h10;
    // Widths
    localparam int CNT_W = 16;
    localparam int LFSR_W = 10;
    // Reset values
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] BIO_CTRL_RST = 16'h0000;
    localparam logic [9:0] LFSR_RST = 10'h001;
    // Feedback tap below the top stage
    localparam int LFSR_TAP = 6;
    // Status field positions
    localparam int ST_NEG = 0;
    localparam int ST_ZERO = 1;
    localparam int ST_LV = 2;
    localparam int ST_MV = 3;
    localparam int ST_RAND = 4;
    localparam int ST_BIO_ARM = 5;
    localparam int ST_LOCK = 6;
    localparam int ST_BUSY = 7;
    localparam int ST_PARITY = 8;
    localparam int ST_MINUS1 = 9;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** test/cfe_seq_model.sv ***
// Instruction sequencer model: issues one condition test per high cycle.
// Assumes bench requests change just after the rising edge of aclk.
`timescale 1ns/1ps
module cfe_seq_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bench request
    input wire logic issue,
    input wire logic [4:0] issue_code,
    // Test port
    output logic test_valid,
    output logic [4:0] test_code
);
    logic [4:0] last_code_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_code_reg <= 5'h00;
        end else if (issue) begin
            last_code_reg <= issue_code;
        end
    end
    // Code is not held between tests
    assign test_valid = issue;
    assign test_code = issue ? issue_code : ~last_code_reg;
endmodule // cfe_seq_model

// *** test/condition_flag_evaluator_bench.sv ***
// Testbench for the condition flag evaluator.
// Assumes cfe_pkg, cfe_core and cfe_seq_model are compiled first.
`timescale 1ns/1ps
module condition_flag_evaluator_bench;
    logic aclk, aresetn, issue, test_valid, cond_true, got;
    logic [4:0] issue_code, test_code;
    logic dau_update, dau_negative, dau_zero, dau_logical_ovf, dau_math_ovf;
    logic [3:0] bit_io_tested, bit_io_matched, hit, miss;
    logic [15:0] bit_io_ctrl, bmu_result;
    logic bmu_update, debug_prog_irq, testport_irq, pll_locked, coproc_busy;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [9:0] lfsr;
    logic [29:0] rows [$];
    int miscompares, num_checks, cycles, ones;

    cfe_seq_model SEQ (.aclk(aclk), .aresetn(aresetn), .issue(issue), .issue_code(issue_code),
        .test_valid(test_valid), .test_code(test_code));
    cfe_core DUT (.aclk(aclk), .aresetn(aresetn), .test_valid(test_valid),
        .test_code(test_code), .cond_true(cond_true), .dau_update(dau_update),
        .dau_negative(dau_negative), .dau_zero(dau_zero), .dau_logical_ovf(dau_logical_ovf),
        .dau_math_ovf(dau_math_ovf), .bit_io_tested(bit_io_tested),
        .bit_io_matched(bit_io_matched), .bit_io_ctrl(bit_io_ctrl), .bmu_update(bmu_update),
        .bmu_result(bmu_result), .debug_prog_irq(debug_prog_irq), .testport_irq(testport_irq),
        .pll_locked(pll_locked), .coproc_busy(coproc_busy), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 12000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
            miscompares++;
        end
    endtask

    task automatic eval(input logic [4:0] code, input logic exp, output logic res);
        issue <= 1'h1;
        issue_code <= code;
        @(negedge aclk);
        res = cond_true;
        chk("cond_true", {31'h0, exp}, {31'h0, res});
        @(posedge aclk);
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic ad, wd;
        ad = 1'h0;
        wd = 1'h0;
        awaddr <= a;
        wdata <= v;
        {awvalid, wvalid} <= 2'h3;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && awready) begin
                ad = 1'h1;
                awvalid <= 1'h0;
            end
            if (!wd && wready) begin
                wd = 1'h1;
                wvalid <= 1'h0;
            end
        end
        bready <= 1'h1;
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
        bready <= 1'h0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        rready <= 1'h1;
        do @(posedge aclk); while (!rvalid);
        v = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask

    task automatic cnt_test(input logic [7:0] off, input logic [4:0] ge, input logic [15:0] start);
        logic [15:0] c;
        logic [1:0] rs;
        logic [31:0] v;
        logic res;
        axi_write(off, {16'h0, start}, rs);
        chk("count_wr_resp", 32'h0, {30'h0, rs});
        c = start;
        for (int k = 0; k < 4; k++) begin
            eval(ge + 5'(k % 2), (k % 2 != 0) ? c[15] : !c[15], res);
            c = c + 16'h1;
        end
        issue <= 1'h0;
        axi_read(off, v, rs);
        chk("count", {16'h0, c}, v);
        $display("test counter %h done", off);
    endtask

    initial begin
        {aresetn, issue, dau_update, dau_negative, dau_zero, dau_logical_ovf} = '0;
        {dau_math_ovf, bmu_update, debug_prog_irq, testport_irq, pll_locked, coproc_busy} = '0;
        {issue_code, bit_io_tested, bit_io_matched, bmu_result, awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        rows = '{{8'h00, 16'h0000, 5'h00, 1'h1}, {8'h80, 16'h0000, 5'h00, 1'h0},
            {8'h80, 16'h0000, 5'h01, 1'h1}, {8'h00, 16'h0000, 5'h01, 1'h0},
            {8'h40, 16'h0000, 5'h02, 1'h1}, {8'h00, 16'h0000, 5'h02, 1'h0},
            {8'h40, 16'h0000, 5'h03, 1'h0}, {8'h00, 16'h0000, 5'h03, 1'h1},
            {8'h00, 16'h0000, 5'h04, 1'h1}, {8'h80, 16'h0000, 5'h04, 1'h0},
            {8'h40, 16'h0000, 5'h04, 1'h0}, {8'hc0, 16'h0000, 5'h05, 1'h1},
            {8'h00, 16'h0000, 5'h05, 1'h0}, {8'h20, 16'h0000, 5'h06, 1'h1},
            {8'h00, 16'h0000, 5'h06, 1'h0}, {8'h20, 16'h0000, 5'h07, 1'h0},
            {8'h00, 16'h0000, 5'h07, 1'h1}, {8'h10, 16'h0000, 5'h08, 1'h1},
            {8'h00, 16'h0000, 5'h08, 1'h0}, {8'h10, 16'h0000, 5'h09, 1'h0},
            {8'h00, 16'h0000, 5'h09, 1'h1}, {8'hf0, 16'h0000, 5'h10, 1'h1},
            {8'hff, 16'h0000, 5'h11, 1'h0}, {8'h00, 16'hffff, 5'h18, 1'h1},
            {8'h00, 16'hffff, 5'h19, 1'h0}, {8'h00, 16'hfffe, 5'h18, 1'h0},
            {8'h00, 16'hfffe, 5'h19, 1'h1}, {8'h00, 16'h0007, 5'h16, 1'h1},
            {8'h00, 16'h0007, 5'h17, 1'h0}, {8'h00, 16'h0003, 5'h16, 1'h0},
            {8'h00, 16'h0003, 5'h17, 1'h1}, {8'h08, 16'h0000, 5'h1a, 1'h0},
            {8'h00, 16'h0000, 5'h1a, 1'h1}, {8'h04, 16'h0000, 5'h1b, 1'h0},
            {8'h00, 16'h0000, 5'h1b, 1'h1}, {8'h02, 16'h0000, 5'h1c, 1'h1},
            {8'h00, 16'h0000, 5'h1c, 1'h0}, {8'h01, 16'h0000, 5'h1d, 1'h1},
            {8'h00, 16'h0000, 5'h1d, 1'h0}, {8'h0f, 16'h0000, 5'h1e, 1'h0},
            {8'hff, 16'hffff, 5'h1f, 1'h0}};
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        axi_read(cfe_pkg::OFF_COUNT_A, d, r);
        chk("count_a_rst", 32'h0, d);
        axi_read(cfe_pkg::OFF_SEED, d, r);
        chk("seed_rst", {22'h0, cfe_pkg::LFSR_RST}, d);
        $display("test reset done");
        foreach (rows[i]) begin
            {dau_negative, dau_zero, dau_logical_ovf, dau_math_ovf} <= rows[i][29:26];
            {debug_prog_irq, testport_irq, pll_locked, coproc_busy} <= rows[i][25:22];
            bmu_result <= rows[i][21:6];
            {dau_update, bmu_update, issue} <= 3'h6;
            @(posedge aclk);
            {dau_update, bmu_update} <= 2'h0;
            eval(rows[i][5:1], rows[i][0], got);
        end
        {dau_update, dau_negative, issue} <= 3'h6;
        @(posedge aclk);
        {dau_update, dau_negative} <= 2'h0;
        eval(cfe_pkg::TC_NEG, 1'h1, got);
        issue <= 1'h0;
        axi_read(cfe_pkg::OFF_STATUS, d, r);
        chk("status_neg", 32'h1, {31'h0, d[cfe_pkg::ST_NEG]});
        chk("status", 32'h000002df, d);
        $display("test table done");
        cnt_test(cfe_pkg::OFF_COUNT_A, cfe_pkg::TC_CA_GE, 16'hfffe);
        cnt_test(cfe_pkg::OFF_COUNT_B, cfe_pkg::TC_CB_GE, 16'h7ffe);
        axi_read(cfe_pkg::OFF_COUNT_A, d, r);
        chk("count_a_kept", 32'h2, d);
        lfsr = cfe_pkg::LFSR_RST;
        ones = 0;
        for (int k = 0; k < 1023; k++) begin
            eval((k % 2 != 0) ? cfe_pkg::TC_TAILS : cfe_pkg::TC_HEADS, lfsr[0] ^ k[0], got);
            ones += int'(got ^ k[0]);
            lfsr = {lfsr[8:0], lfsr[9] ^ lfsr[6]};
        end
        issue <= 1'h0;
        chk("heads_count", 32'h200, 32'(ones));
        axi_read(cfe_pkg::OFF_SEED, d, r);
        chk("seed_after", {22'h0, lfsr}, d);
        $display("test random done");
        axi_write(cfe_pkg::OFF_SEED, 32'h2a5, r);
        axi_write(cfe_pkg::OFF_SEED, 32'h0, r);
        axi_read(cfe_pkg::OFF_SEED, d, r);
        chk("seed_wr", 32'h2a5, d);
        eval(cfe_pkg::TC_HEADS, 1'h1, got);
        issue <= 1'h0;
        axi_read(cfe_pkg::OFF_SEED, d, r);
        chk("seed_step", 32'h14b, d);
        $display("test seed done");
        {bit_io_tested, bit_io_matched} <= 8'hff;
        eval(cfe_pkg::TC_ALL_T, 1'h0, got);
        eval(cfe_pkg::TC_SOME_T, 1'h0, got);
        issue <= 1'h0;
        axi_write(cfe_pkg::OFF_BIO_CTRL, 32'h5a5aa50f, r);
        chk("bio_ctrl", 32'h0000a50f, {16'h0, bit_io_ctrl});
        for (int t = 0; t < 16; t++) begin
            for (int m = 0; m < 16; m++) begin
                bit_io_tested <= 4'(t);
                bit_io_matched <= 4'(m);
                hit = 4'(t & m);
                miss = 4'(t & ~m);
                eval(cfe_pkg::TC_ALL_T, miss == 4'h0, got);
                eval(cfe_pkg::TC_ALL_F, hit == 4'h0, got);
                eval(cfe_pkg::TC_SOME_T, hit != 4'h0, got);
                eval(cfe_pkg::TC_SOME_F, miss != 4'h0, got);
            end
        end
        issue <= 1'h0;
        $display("test bit io done");
        axi_write(8'h14, 32'h1, r);
        chk("unmapped_wr", {30'h0, cfe_pkg::RESP_SLVERR}, {30'h0, r});
        axi_read(8'h14, d, r);
        chk("unmapped_rd", {30'h0, cfe_pkg::RESP_SLVERR}, {30'h0, r});
        chk("unmapped_data", 32'h0, d);
        $display("test unmapped done");
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        eval(cfe_pkg::TC_SOME_T, 1'h0, got);
        issue <= 1'h0;
        axi_read(cfe_pkg::OFF_COUNT_B, d, r);
        chk("count_b_rst", 32'h0, d);
        $display("test mid reset done");
        report_and_stop();
    end
endmodule // condition_flag_evaluator_bench
